/* File: tsl_pkg.sv */
// Purpose: shared constants and carriers for the transceiver status bank
// Assumes: 8-bit processor register space, main and alternate banks
// Notes: register indices are the processor's register numbers
package tsl_pkg;
    // register indices
    localparam logic [4:0] TSL_ALT_STATUS_IDX = 5'h05;
    localparam logic [4:0] TSL_MAIN_TIMER_LOW_IDX = 5'h1c;
    localparam logic [4:0] TSL_MAIN_RX_DATA_IDX = 5'h02;
    localparam logic [4:0] TSL_MAIN_ERR_CODE_IDX = 5'h03;
    // status bit positions
    localparam int TSL_BIT_TX_FULL = 7;
    localparam int TSL_BIT_TX_ACTIVE = 6;
    localparam int TSL_BIT_RX_ERROR = 5;
    localparam int TSL_BIT_RX_ACTIVE = 4;
    localparam int TSL_BIT_DATA_AVAIL = 3;
    localparam int TSL_BIT_FIFO_UPPER = 0;
    // sticky flag indices inside the bank
    localparam int TSL_FLAG_ERR = 0;
    localparam int TSL_FLAG_ACT = 1;
    localparam int TSL_FLAG_DAV = 2;
    localparam int TSL_NUM_FLAGS = 3;
    // reset values and sizes
    localparam logic [7:0] TSL_TIMER_LOW_RESET = 8'h00;
    localparam logic [7:0] TSL_RD_RESET = 8'h00;
    localparam int TSL_TX_FIFO_DEPTH = 3;
    localparam int TSL_RX_WORD_W = 11;

    // processor register access, one cycle strobes
    typedef struct packed {
        logic rd;
        logic wr;
        logic alt;
        logic [4:0] idx;
        logic [7:0] wdata;
    } tsl_bus_req_type;

    // receiver events and the receive fifo top word
    typedef struct packed {
        logic start;
        logic eom;
        logic err;
        logic word_valid;
        logic [TSL_RX_WORD_W-1:0] top_word;
    } tsl_rx_evt_type;
endpackage

/* File: tsl_flag.sv */
// Purpose: one sticky status flag with set and clear
// Assumes: set and clear are one-cycle pulses or levels
// Notes: set wins over clear so no event is lost
`timescale 1ns/1ps
`default_nettype none
module tsl_flag (
    input wire logic clk,  // core clock
    input wire logic rstn, // async reset, low
    input wire logic set,  // event sets flag
    input wire logic clr,  // clear request
    output logic q         // flag value
);
    typedef struct packed {
        logic flag;
    } tsl_flag_state_type;

    tsl_flag_state_type st_ff;
    tsl_flag_state_type nxt_st;

    // set dominates so an event in the clearing cycle survives
    always_comb begin
        nxt_st = st_ff;
        if (set) begin
            nxt_st.flag = 1'b1;
        end else if (clr) begin
            nxt_st.flag = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.flag;

    AST_SET_WINS: assert property (@(posedge clk) disable iff (!rstn)
        set |=> q)
        else $error("flag lost a set");
endmodule // tsl_flag
`default_nettype wire

/* File: tsl_timer_low.sv */
// Purpose: low byte of the processor timer, readable and loadable
// Assumes: run is a level from the timer control
// Notes: carry pulses on wrap so the high byte can count
`timescale 1ns/1ps
`default_nettype none
module tsl_timer_low (
    input wire logic clk,        // core clock
    input wire logic rstn,       // async reset, low
    input wire logic run,        // count enable level
    input wire logic load,       // processor write strobe
    input wire logic [7:0] wdata, // value to load
    output logic [7:0] count,    // current low byte
    output logic carry           // wrap pulse
);
    import tsl_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic carry;
    } tsl_timer_state_type;

    tsl_timer_state_type st_ff;
    tsl_timer_state_type nxt_st;

    // a write wins over counting so software sees its own value
    always_comb begin
        nxt_st = st_ff;
        nxt_st.carry = 1'b0;
        if (load) begin
            nxt_st.cnt = wdata;
        end else if (run) begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
            nxt_st.carry = (st_ff.cnt == 8'hff);
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '{cnt: TSL_TIMER_LOW_RESET, carry: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign count = st_ff.cnt;
    assign carry = st_ff.carry;

    // a load shows in the count on the next edge
    AST_TIMER_LOAD: assert property (
        @(posedge clk) disable iff (!rstn)
        load |=> count == $past(wdata))
        else $error("timer low load not taken");
endmodule // tsl_timer_low
`default_nettype wire

/* File: tsl_status_bank.sv */
// Purpose: transceiver status register and timer low byte in the
//          processor register space
// Assumes: receiver and transmitter give event pulses and levels
//          synchronous to clk
// Notes: read data is registered, valid one cycle after the strobe
//
// Summary of operation
// - Status is an 8-bit read-only register at alternate index 5.
// - Transmit-full bit is high while transmit fifo holds max entries.
// - Transmitter-active bit follows tx_sending, not the transmitter-active output.
// - Transmitter-active bit still reports sending during loopback.
// - Receiver-error bit sets on any reception error.
// - Receiver-error clears on error code read or transceiver reset.
// - Receiver-active bit sets on a valid starting sequence.
// - Receiver-active clears on end of message or receive error.
// - In 5250 modes receiver-active clears with the line-active flag.
// - Data-available sets when valid received data is presented.
// - Data-available clears on receive data read or receive error.
// - Status bits 2..0 show upper three bits of fifo top word.
// - Main index 28 is the read/write timer low byte.
`timescale 1ns/1ps
`default_nettype none
module tsl_status_bank #(
    parameter int TX_FIFO_DEPTH = tsl_pkg::TSL_TX_FIFO_DEPTH,
    parameter int CNT_W = $clog2(TX_FIFO_DEPTH + 1)
) (
    input wire logic clk,                       // core clock, 20 MHz
    input wire logic rstn,                      // async reset, low
    input wire tsl_pkg::tsl_bus_req_type bus_req, // register access
    input wire tsl_pkg::tsl_rx_evt_type rx_evt, // receiver events
    input wire logic [CNT_W-1:0] tx_fifo_count, // transmit entries
    input wire logic tx_sending,                // serial data going out
    input wire logic loopback_en,               // internal loopback
    input wire logic transceiver_reset_bit,     // transceiver reset
    input wire logic line_active_flag,          // line activity
    input wire logic mode_5250,                 // 5250 protocol chosen
    input wire logic timer_run,                 // timer count enable
    output logic [7:0] rd_data,                 // read data
    output logic rd_hit,                        // read was decoded here
    output logic tx_active_output,              // transmitter pin
    output logic rx_fifo_pop,                   // receive word consumed
    output logic timer_low_carry                // low byte wrapped
);
    import tsl_pkg::*;

    typedef struct packed {
        logic [7:0] rd_data;
        logic rd_hit;
        logic tx_active_pin;
        logic tx_active_flag;
        logic tx_fifo_full;
        logic [2:0] rx_upper;
        logic rx_pop;
    } tsl_bank_state_type;

    tsl_bank_state_type st_ff;
    tsl_bank_state_type nxt_st;

    logic [TSL_NUM_FLAGS-1:0] flag_set;
    logic [TSL_NUM_FLAGS-1:0] flag_clr;
    logic [TSL_NUM_FLAGS-1:0] flag_q;
    logic [7:0] status_word;
    logic [7:0] timer_count;
    logic rd_status;
    logic rd_rx_data;
    logic rd_err_code;
    logic rd_timer;
    logic wr_timer;
    logic ra_line_clr;

    // address decode of the two banks
    always_comb begin
        rd_status = bus_req.rd && bus_req.alt &&
                    (bus_req.idx == TSL_ALT_STATUS_IDX);
        rd_rx_data = bus_req.rd && !bus_req.alt &&
                     (bus_req.idx == TSL_MAIN_RX_DATA_IDX);
        rd_err_code = bus_req.rd && !bus_req.alt &&
                      (bus_req.idx == TSL_MAIN_ERR_CODE_IDX);
        rd_timer = bus_req.rd && !bus_req.alt &&
                   (bus_req.idx == TSL_MAIN_TIMER_LOW_IDX);
        wr_timer = bus_req.wr && !bus_req.alt &&
                   (bus_req.idx == TSL_MAIN_TIMER_LOW_IDX);
    end

    // in 5250 modes a dropping line clears receiver-active with it
    assign ra_line_clr = mode_5250 && !line_active_flag;

    // event and clear sources of the sticky flags
    always_comb begin
        flag_set = '0;
        flag_clr = '0;
        flag_set[TSL_FLAG_ERR] = rx_evt.err;
        flag_clr[TSL_FLAG_ERR] = rd_err_code ||
                                 transceiver_reset_bit;
        flag_set[TSL_FLAG_ACT] = rx_evt.start;
        flag_clr[TSL_FLAG_ACT] = rx_evt.eom || rx_evt.err ||
                                 ra_line_clr;
        flag_set[TSL_FLAG_DAV] = rx_evt.word_valid;
        flag_clr[TSL_FLAG_DAV] = rd_rx_data || rx_evt.err;
    end

    // one sticky flag per receiver status bit
    for (genvar i = 0; i < TSL_NUM_FLAGS; i++) begin : g_flag
        tsl_flag u_flag (
            .clk(clk),
            .rstn(rstn),
            .set(flag_set[i]),
            .clr(flag_clr[i]),
            .q(flag_q[i])
        );
    end

    // timer low byte lives in its own small counter
    tsl_timer_low u_timer (
        .clk(clk),
        .rstn(rstn),
        .run(timer_run),
        .load(wr_timer),
        .wdata(bus_req.wdata),
        .count(timer_count),
        .carry(timer_low_carry)
    );

    // status word as software sees it
    always_comb begin
        status_word = '0;
        status_word[TSL_BIT_TX_FULL] = st_ff.tx_fifo_full;
        status_word[TSL_BIT_TX_ACTIVE] = st_ff.tx_active_flag;
        status_word[TSL_BIT_RX_ERROR] = flag_q[TSL_FLAG_ERR];
        status_word[TSL_BIT_RX_ACTIVE] = flag_q[TSL_FLAG_ACT];
        status_word[TSL_BIT_DATA_AVAIL] = flag_q[TSL_FLAG_DAV];
        status_word[TSL_BIT_FIFO_UPPER +: 3] = st_ff.rx_upper;
    end

    // next state; status writes have no decode so they fall away
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tx_fifo_full =
            (tx_fifo_count == CNT_W'(TX_FIFO_DEPTH));
        // flag keeps tracking while the pin is silenced
        nxt_st.tx_active_flag = tx_sending;
        nxt_st.tx_active_pin = tx_sending && !loopback_en;
        nxt_st.rx_upper = rx_evt.top_word[10:8];
        nxt_st.rx_pop = rd_rx_data;
        nxt_st.rd_hit = rd_status || rd_rx_data || rd_timer;
        nxt_st.rd_data = TSL_RD_RESET;
        if (rd_status) begin
            nxt_st.rd_data = status_word;
        end else if (rd_rx_data) begin
            nxt_st.rd_data = rx_evt.top_word[7:0];
        end else if (rd_timer) begin
            nxt_st.rd_data = timer_count;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '{rd_data: TSL_RD_RESET, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data = st_ff.rd_data;
    assign rd_hit = st_ff.rd_hit;
    assign tx_active_output = st_ff.tx_active_pin;
    assign rx_fifo_pop = st_ff.rx_pop;

    // checks
    sequence s_status_read;
        rd_status ##1 rd_hit;
    endsequence

    sequence s_err_code_read;
        rd_err_code && !rx_evt.err;
    endsequence

    // read data carries the word seen at the decode edge
    AST_STATUS_READ: assert property (
        @(posedge clk) disable iff (!rstn)
        s_status_read |-> rd_data == $past(status_word))
        else $error("status read data wrong");

    // a status write with no flag event leaves every flag alone
    AST_STATUS_WR: assert property (
        @(posedge clk) disable iff (!rstn)
        bus_req.wr && bus_req.alt && (bus_req.idx == TSL_ALT_STATUS_IDX) &&
        !(|flag_set) && !(|flag_clr) |=> $stable(flag_q))
        else $error("status write changed a flag");

    // reads decoded elsewhere must not answer from here
    AST_RD_MISS: assert property (
        @(posedge clk) disable iff (!rstn)
        bus_req.rd && !rd_status && !rd_rx_data && !rd_timer |=>
        !rd_hit && rd_data == TSL_RD_RESET)
        else $error("unmapped read answered");

    // full bit rises with a full fifo
    AST_TX_FULL: assert property (
        @(posedge clk) disable iff (!rstn)
        tx_fifo_count == CNT_W'(TX_FIFO_DEPTH) |=>
        status_word[TSL_BIT_TX_FULL])
        else $error("transmit full not shown");

    // and stays low while there is room
    AST_NOT_FULL: assert property (
        @(posedge clk) disable iff (!rstn)
        tx_fifo_count != CNT_W'(TX_FIFO_DEPTH) |=>
        !status_word[TSL_BIT_TX_FULL])
        else $error("transmit full shown with room");

    // outside loopback the flag and the pin agree
    AST_TX_ACTIVE: assert property (
        @(posedge clk) disable iff (!rstn)
        !loopback_en |=>
        status_word[TSL_BIT_TX_ACTIVE] == tx_active_output)
        else $error("tx active flag differs from pin");

    // nothing sending shows nothing active
    AST_TX_IDLE: assert property (
        @(posedge clk) disable iff (!rstn)
        !tx_sending |=>
        !status_word[TSL_BIT_TX_ACTIVE] && !tx_active_output)
        else $error("tx active without sending");

    // loopback silences the pin but not the flag
    AST_LOOP: assert property (
        @(posedge clk) disable iff (!rstn)
        tx_sending && loopback_en |=>
        status_word[TSL_BIT_TX_ACTIVE] && !tx_active_output)
        else $error("loopback handling wrong");

    // the pin stays quiet for any loopback cycle
    AST_LOOP_PIN: assert property (
        @(posedge clk) disable iff (!rstn)
        loopback_en |=> !tx_active_output)
        else $error("pin driven in loopback");

    // error sets its bit and drops data unless a word came with it
    AST_ERR_SET: assert property (
        @(posedge clk) disable iff (!rstn)
        rx_evt.err |=> status_word[TSL_BIT_RX_ERROR] &&
        (!status_word[TSL_BIT_DATA_AVAIL] || $past(rx_evt.word_valid)))
        else $error("error not flagged");

    // error is sticky until one of its clears
    AST_ERR_HOLD: assert property (
        @(posedge clk) disable iff (!rstn)
        status_word[TSL_BIT_RX_ERROR] && !rd_err_code &&
        !transceiver_reset_bit |=> status_word[TSL_BIT_RX_ERROR])
        else $error("error dropped on its own");

    // error code read clears the error
    AST_ERR_CLR: assert property (
        @(posedge clk) disable iff (!rstn)
        s_err_code_read |=> !status_word[TSL_BIT_RX_ERROR])
        else $error("error code read did not clear");

    // transceiver reset clears the error too
    AST_ERR_TRANSCEIVER_RESET_BIT: assert property (
        @(posedge clk) disable iff (!rstn)
        transceiver_reset_bit && !rx_evt.err |=>
        !status_word[TSL_BIT_RX_ERROR])
        else $error("transceiver reset did not clear");

    // a starting sequence raises receiver-active
    AST_RA_SET: assert property (
        @(posedge clk) disable iff (!rstn)
        rx_evt.start |=> status_word[TSL_BIT_RX_ACTIVE])
        else $error("receiver active not set");

    // end of message or error drops it
    AST_RA_CLR: assert property (
        @(posedge clk) disable iff (!rstn)
        (rx_evt.eom || rx_evt.err) && !rx_evt.start |=>
        !status_word[TSL_BIT_RX_ACTIVE])
        else $error("receiver active not cleared");

    // in 5250 modes it goes with the line
    AST_RA_5250: assert property (
        @(posedge clk) disable iff (!rstn)
        mode_5250 && $fell(line_active_flag) && !rx_evt.start |=>
        !status_word[TSL_BIT_RX_ACTIVE])
        else $error("receiver active outlived line");

    // a received word shows as available
    AST_DAV_SET: assert property (
        @(posedge clk) disable iff (!rstn)
        rx_evt.word_valid |=> status_word[TSL_BIT_DATA_AVAIL])
        else $error("data available not set");

    // available stays until read or error
    AST_DAV_HOLD: assert property (
        @(posedge clk) disable iff (!rstn)
        status_word[TSL_BIT_DATA_AVAIL] && !rd_rx_data && !rx_evt.err |=>
        status_word[TSL_BIT_DATA_AVAIL])
        else $error("data available dropped on its own");

    // a data read clears available and pops the fifo
    AST_DAV_CLR: assert property (
        @(posedge clk) disable iff (!rstn)
        rd_rx_data && !rx_evt.word_valid |=>
        !status_word[TSL_BIT_DATA_AVAIL] && rx_fifo_pop)
        else $error("data read did not clear");

    // an error clears available as well
    AST_DAV_ERR: assert property (
        @(posedge clk) disable iff (!rstn)
        rx_evt.err && !rx_evt.word_valid |=>
        !status_word[TSL_BIT_DATA_AVAIL])
        else $error("error did not clear data available");

    // upper bits follow the fifo top word a cycle late
    AST_UPPER: assert property (
        @(posedge clk) disable iff (!rstn)
        ##1 status_word[2:0] == $past(rx_evt.top_word[10:8]))
        else $error("fifo upper bits wrong");

    // data read returns the lower bits of the same word
    AST_RX_DATA_READ: assert property (
        @(posedge clk) disable iff (!rstn)
        rd_rx_data |=> rd_data == $past(rx_evt.top_word[7:0]))
        else $error("receive data read wrong");

    // timer read returns the count seen at the decode edge
    AST_TIMER_READ: assert property (
        @(posedge clk) disable iff (!rstn)
        rd_timer |=> rd_hit && rd_data == $past(timer_count))
        else $error("timer low read wrong");
endmodule // tsl_status_bank
`default_nettype wire

/* File: tsl_cpu_model.sv */
// Purpose: processor core model issuing register reads and writes
// Assumes: one access at a time, strobes one clock wide
// Notes: answer sampled mid-cycle so it never races the launch edge
`timescale 1ns/1ps
`default_nettype none
module tsl_cpu_model (
    input wire logic clk,                          // core clock
    input wire logic tx_full,                      // transmit fifo full
    input wire logic [7:0] rd_data,                // read data from bank
    input wire logic rd_hit,                       // read decoded flag
    output var tsl_pkg::tsl_bus_req_type bus_req   // register access
);
    import tsl_pkg::*;

    // bus idle from time zero
    initial begin
        bus_req = '0;
    end

    // one access, strobe taken at the second edge, then released
    task automatic access(input logic rd, input logic wr, input logic alt,
        input logic [4:0] idx, input logic [7:0] wdata,
        output logic [7:0] d, output logic h);
        // software holds data writes back while the fifo is full
        if (wr && !alt && idx == TSL_MAIN_RX_DATA_IDX && tx_full) begin
            wr = 1'b0;
        end
        @(posedge clk);
        bus_req <= '{rd: rd, wr: wr, alt: alt, idx: idx, wdata: wdata};
        @(posedge clk);
        bus_req <= '0;
        @(negedge clk);
        d = rd_data;
        h = rd_hit;
    endtask
endmodule // tsl_cpu_model
`default_nettype wire

/* File: testbench.sv */
// Purpose: self-checking bench for the transceiver status bank
// Assumes: processor model drives the register bus
// Notes: status reads wait two cycles so tracked bits settle
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tsl_pkg::*;
    typedef struct packed {
        logic [1:0] cnt;
        logic snd;
        logic lpb;
        logic [10:0] word;
        logic [7:0] exp;
        logic txo;
    } tsl_row_type;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    tsl_bus_req_type bus_req;
    tsl_rx_evt_type rx_evt = '0;
    logic [1:0] tx_fifo_count = 2'h0;
    logic tx_sending = 1'b0;
    logic loopback_en = 1'b0;
    logic transceiver_reset_bit = 1'b0;
    logic line_active_flag = 1'b0;
    logic mode_5250 = 1'b0;
    logic timer_run = 1'b0;
    logic [7:0] rd_data;
    logic rd_hit;
    logic tx_active_output;
    logic rx_fifo_pop;
    logic timer_low_carry;
    int fails = 0;
    int total_checks = 0;
    int carries = 0;
    // tracked bits: fifo count, sending, loopback, fifo top word
    tsl_row_type rows [4] = '{
        '{2'h3, 1'b0, 1'b0, 11'h500, 8'h85, 1'b0},
        '{2'h2, 1'b1, 1'b0, 11'h2ff, 8'h42, 1'b1},
        '{2'h0, 1'b1, 1'b1, 11'h700, 8'h47, 1'b0},
        '{2'h1, 1'b0, 1'b1, 11'h000, 8'h00, 1'b0}};

    tsl_status_bank DUT (.clk(clk), .rstn(rstn), .bus_req(bus_req),
        .rx_evt(rx_evt), .tx_fifo_count(tx_fifo_count),
        .tx_sending(tx_sending), .loopback_en(loopback_en),
        .transceiver_reset_bit(transceiver_reset_bit),
        .line_active_flag(line_active_flag), .mode_5250(mode_5250),
        .timer_run(timer_run), .rd_data(rd_data), .rd_hit(rd_hit),
        .tx_active_output(tx_active_output), .rx_fifo_pop(rx_fifo_pop),
        .timer_low_carry(timer_low_carry));
    tsl_cpu_model cpu (.clk(clk), .tx_full(tx_fifo_count == 2'h3),
        .rd_data(rd_data), .rd_hit(rd_hit), .bus_req(bus_req));

    // 50 ns period
    always #25 clk = ~clk;

    // carry pulses are counted, not caught mid-cycle
    always @(posedge clk) begin
        if (timer_low_carry === 1'b1) begin
            carries <= carries + 1;
        end
    end

    task automatic end_sim;
        if (fails == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic alt, input logic [4:0] idx,
        output logic [7:0] d);
        logic h;
        cpu.access(1'b1, 1'b0, alt, idx, 8'h00, d, h);
    endtask

    task automatic wr(input logic alt, input logic [4:0] idx,
        input logic [7:0] v);
        logic [7:0] d;
        logic h;
        cpu.access(1'b0, 1'b1, alt, idx, v, d, h);
    endtask

    // read status after settling, check data and hit
    task automatic st(input logic [7:0] exp);
        logic [7:0] d;
        logic h;
        repeat (2) @(posedge clk);
        cpu.access(1'b1, 1'b0, 1'b1, TSL_ALT_STATUS_IDX, 8'h00, d, h);
        chk(d, exp);
        chk({7'h0, h}, 8'h01);
    endtask

    // one-cycle receiver event: start, eom, err, word_valid
    task automatic evt(input logic [3:0] e);
        @(posedge clk);
        rx_evt <= {e, rx_evt.top_word};
        @(posedge clk);
        rx_evt <= {4'h0, rx_evt.top_word};
    endtask

    // hang guard, well beyond the expected run
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        end_sim;
    end

    initial begin
        logic [7:0] d;
        logic h;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        st(8'h00);
        rd(1'b0, TSL_MAIN_TIMER_LOW_IDX, d);
        chk(d, TSL_TIMER_LOW_RESET);
        // ordinary cases from the table
        foreach (rows[i]) begin
            @(posedge clk);
            tx_fifo_count <= rows[i].cnt;
            tx_sending <= rows[i].snd;
            loopback_en <= rows[i].lpb;
            rx_evt.top_word <= rows[i].word;
            st(rows[i].exp);
            chk({7'h0, tx_active_output}, {7'h0, rows[i].txo});
        end
        // status ignores writes; timer loads, reads back, wraps
        wr(1'b1, TSL_ALT_STATUS_IDX, 8'hff);
        st(8'h00);
        wr(1'b0, TSL_MAIN_TIMER_LOW_IDX, 8'ha5);
        rd(1'b0, TSL_MAIN_TIMER_LOW_IDX, d);
        chk(d, 8'ha5);
        wr(1'b0, TSL_MAIN_TIMER_LOW_IDX, 8'hfd);
        @(posedge clk);
        timer_run <= 1'b1;
        repeat (6) @(posedge clk);
        timer_run <= 1'b0;
        @(posedge clk);
        chk(carries[7:0], 8'h01);
        // unmapped index gives nothing
        cpu.access(1'b1, 1'b0, 1'b0, 5'h1f, 8'h00, d, h);
        chk(d, 8'h00);
        chk({7'h0, h}, 8'h00);
        // message with data, read pops and clears, end clears active
        @(posedge clk);
        rx_evt.top_word <= 11'h3a5;
        evt(4'b1001);
        st(8'h1b);
        rd(1'b0, TSL_MAIN_RX_DATA_IDX, d);
        chk(d, 8'ha5);
        chk({7'h0, rx_fifo_pop}, 8'h01);
        st(8'h13);
        evt(4'b0100);
        st(8'h03);
        @(posedge clk);
        rx_evt.top_word <= 11'h000;
        // error drops active and data, cleared by code read or reset
        evt(4'b1001);
        evt(4'b0010);
        st(8'h20);
        rd(1'b0, TSL_MAIN_ERR_CODE_IDX, d);
        st(8'h00);
        evt(4'b0010);
        st(8'h20);
        @(posedge clk);
        transceiver_reset_bit <= 1'b1;
        @(posedge clk);
        transceiver_reset_bit <= 1'b0;
        st(8'h00);
        // 5250 mode: active falls with line activity
        @(posedge clk);
        mode_5250 <= 1'b1;
        line_active_flag <= 1'b1;
        evt(4'b1000);
        st(8'h10);
        @(posedge clk);
        line_active_flag <= 1'b0;
        st(8'h00);
        // mid-run reset drops sticky flags and the timer count
        evt(4'b0010);
        evt(4'b0001);
        st(8'h28);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        st(8'h00);
        rd(1'b0, TSL_MAIN_TIMER_LOW_IDX, d);
        chk(d, TSL_TIMER_LOW_RESET);
        end_sim;
    end
endmodule // testbench
`default_nettype wire
